//--- rtl/pmic_pkg.sv
// Constants, register map and carrier types of the input control block.
// Assumes one clock domain and a 32-bit APB master.
package pmic_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam int unsigned    PMIC_AW          = 12;
    localparam logic [11:0]    PMIC_OFF_CTRL    = 12'h000;
    localparam logic [11:0]    PMIC_OFF_OUTSEL  = 12'h004;
    localparam logic [11:0]    PMIC_OFF_STATUS  = 12'h008;
    localparam logic [11:0]    PMIC_OFF_IRQ_ST  = 12'h00c;
    localparam logic [11:0]    PMIC_OFF_IRQ_MSK = 12'h010;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int unsigned    CTRL_MODE_LSB    = 0;
    localparam int unsigned    CTRL_MODE_MSB    = 3;
    localparam int unsigned    CTRL_CAM_POL     = 4;
    localparam int unsigned    CTRL_FORCE_FWD   = 5;
    localparam int unsigned    CTRL_FORCE_REV   = 6;
    localparam int unsigned    CTRL_STOP_SLOW   = 7;
    localparam int unsigned    CTRL_FWD_MAPPED  = 8;
    localparam int unsigned    CTRL_REV_MAPPED  = 9;
    localparam int unsigned    CTRL_W           = 10;
    localparam logic [9:0]     CTRL_RST         = 10'h300;
    localparam logic [3:0]     MODE_HOME_RETURN = 4'h7;

    // ----------------------------------------------------------------
    // Output pin assignment: one byte per pin
    // ----------------------------------------------------------------
    localparam int unsigned    OUT_PINS         = 4;
    localparam int unsigned    OUT_CODE_W       = 8;
    localparam logic [7:0]     FUNC_NONE        = 8'h00;
    localparam logic [7:0]     FUNC_FAULT       = 8'h03;
    localparam logic [7:0]     FUNC_WARNING     = 8'h07;
    localparam logic [7:0]     FUNC_TRAVEL_DONE = 8'h18;
    localparam logic [31:0]    OUTSEL_RST       = 32'h0007_1803;

    // ----------------------------------------------------------------
    // Interrupt bits, status fields and warning codes
    // ----------------------------------------------------------------
    localparam int unsigned    IRQ_FSTOP        = 0;
    localparam int unsigned    IRQ_STROKE       = 1;
    localparam int unsigned    IRQ_ALARM        = 2;
    localparam int unsigned    IRQ_CAM          = 3;
    localparam int unsigned    IRQ_W            = 4;
    localparam logic [7:0]     WARN_NONE        = 8'h00;
    localparam logic [7:0]     WARN_STROKE      = 8'h63;
    localparam int unsigned    ST_WARN_LSB      = 16;
    localparam int unsigned    SYNC_W           = 8;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic auto_manual_select;
        logic prog_select_bit3;
        logic prog_select_bit2;
        logic prog_select_bit1;
        logic forced_stop_input;
        logic prox_cam_input;
        logic fwd_stroke_end_input;
        logic rev_stroke_end_input;
    } pmic_pins_t;

    typedef struct packed {
        logic       run_auto;
        logic       run_jog;
        logic       home_return_mode;
        logic [2:0] prog_number;
        logic       power_stage_on;
        logic       dyn_brake;
        logic       sudden_stop;
        logic       slow_stop;
        logic       servo_lock;
        logic       allow_ccw;
        logic       allow_cw;
        logic       cam_detect;
    } pmic_drive_t;

    typedef enum logic [1:0] {
        PMIC_RUN   = 2'b01,
        PMIC_FSTOP = 2'b10
    } pmic_state_t;

endpackage

//--- rtl/pmic_top.sv
// Mode, forced stop, stroke-end and cam handling with APB registers.
// Assumes async pins; alarm and travel status from pclk logic.
//
// Behaviour
// RULE_01: Select high runs automatic program mode, low runs jog.
// RULE_02: Host sets mode digit 7, select high, program with home-return command.
// RULE_03: Three program-select inputs choose the automatic program number.
// RULE_04: Fault output on without alarm, off with one.
// RULE_05: Unmapped stroke-end inputs read as always on.
// RULE_06: Travel-complete reaches an output pin only with assignment code 24.
// RULE_07: Forced-stop input off enters forced stop: power stage off, brake on.
// RULE_08: Forced stop clears when the forced-stop input returns on.
// RULE_09: Host drives forced-stop input on before starting any operation.
// RULE_10: By default the cam is detected while its input is off.
// RULE_11: A polarity bit chooses off or on as the cam detected level.
// RULE_12: Motion only with stroke ends on; one off stops suddenly, servo-locked.
// RULE_13: A configuration bit selects the stroke-end stopping method.
// RULE_14: Configuration bits force either stroke end on regardless of pin.
// RULE_15: A stroke end off raises warning 99 and drops the warning output.
// RULE_16: Warning output reaches a pin only via an assignment code.
// RULE_17: Four assignment bytes choose each output pin's function.
// RULE_18: Forward end off blocks CCW, reverse end off blocks CW; moving away allowed.
//
// The implementer's own choices: the register offsets and register access over APB.

`timescale 1ns/1ps

module pmic_top (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Discrete input pins (asynchronous)
    input  wire pmic_pkg::pmic_pins_t pins,
    // Status from the drive core (pclk domain)
    input  wire logic                 alarm_active,
    input  wire logic                 travel_done,
    // Commands to the drive core
    output pmic_pkg::pmic_drive_t     drive,
    // Discrete outputs
    output logic                      fault_output,
    output logic                      warning_output,
    output logic      [7:0]           warning_code,
    output logic      [3:0]           out_pins,
    // Interrupt
    output logic                      irq
);
    import pmic_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] pin_vec;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt;

    pmic_pins_t        pin_s;

    assign pin_vec = pins;
    assign pin_s   = filt;

    // Three stages; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    filt[gi]  <= 1'b0;
                end else begin
                    sync1[gi] <= pin_vec[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        filt[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       outsel;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_event;

    logic              wr_en;
    logic              setup;

    logic [3:0]        operation_mode_param;
    logic              cam_polarity_param;
    logic              stroke_stop_method_param;
    logic [1:0]        auto_on_input_param;

    assign operation_mode_param     = ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];
    assign cam_polarity_param       = ctrl[CTRL_CAM_POL];
    assign stroke_stop_method_param = ctrl[CTRL_STOP_SLOW];
    assign auto_on_input_param      = {ctrl[CTRL_FORCE_REV], ctrl[CTRL_FORCE_FWD]};

    // Write lands only at the completing access edge
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign setup = psel && !penable;

    // Control and output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= CTRL_RST;
            outsel   <= OUTSEL_RST;
            irq_mask <= '0;
        end else if (wr_en) begin
            if (paddr == PMIC_OFF_CTRL) begin
                ctrl <= pwdata[CTRL_W-1:0]; // see RULE_13 see RULE_14
            end
            if (paddr == PMIC_OFF_OUTSEL) begin
                outsel <= pwdata; // see RULE_17
            end
            if (paddr == PMIC_OFF_IRQ_MSK) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Effective input levels
    // ----------------------------------------------------------------
    logic fwd_eff;
    logic rev_eff;

    logic cam_now;
    logic any_stroke_off;

    // Unmapped or forced stroke ends read as on, so wiring can be left open
    assign fwd_eff = !ctrl[CTRL_FWD_MAPPED] || auto_on_input_param[0]
                     || pin_s.fwd_stroke_end_input; // see RULE_05 see RULE_14
    assign rev_eff = !ctrl[CTRL_REV_MAPPED] || auto_on_input_param[1]
                     || pin_s.rev_stroke_end_input; // see RULE_05 see RULE_14
    assign any_stroke_off = !fwd_eff || !rev_eff;

    // Detected level: off by default, on with polarity set
    assign cam_now = cam_polarity_param ? pin_s.prox_cam_input
                                        : !pin_s.prox_cam_input; // see RULE_10 see RULE_11

    // ----------------------------------------------------------------
    // Forced-stop state machine
    // ----------------------------------------------------------------
    pmic_state_t state;

    pmic_state_t next_state;

    // Starts stopped: the stop input is active when off, so silence is unsafe
    always_comb begin
        next_state = state;
        unique case (state)
            PMIC_RUN: begin
                if (!pin_s.forced_stop_input) begin
                    next_state = PMIC_FSTOP; // see RULE_07
                end
            end
            PMIC_FSTOP: begin
                if (pin_s.forced_stop_input) begin
                    next_state = PMIC_RUN; // see RULE_08 see RULE_09
                end
            end
            default: next_state = PMIC_FSTOP;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PMIC_FSTOP;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Drive commands
    // ----------------------------------------------------------------
    logic home_sel;

    assign home_sel = pin_s.auto_manual_select
                      && (operation_mode_param == MODE_HOME_RETURN); // see RULE_02

    // All commands registered so the core sees glitch-free levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
        end else begin
            drive.run_auto         <= pin_s.auto_manual_select && !home_sel; // see RULE_01
            drive.run_jog          <= !pin_s.auto_manual_select; // see RULE_01
            drive.home_return_mode <= home_sel;
            drive.prog_number      <= {pin_s.prog_select_bit3, pin_s.prog_select_bit2,
                                       pin_s.prog_select_bit1}; // see RULE_03

            drive.power_stage_on   <= (next_state == PMIC_RUN); // see RULE_07
            drive.dyn_brake        <= (next_state == PMIC_FSTOP); // see RULE_07

            drive.sudden_stop      <= any_stroke_off && !stroke_stop_method_param; // see RULE_12
            drive.slow_stop        <= any_stroke_off && stroke_stop_method_param; // see RULE_13
            drive.servo_lock       <= any_stroke_off; // see RULE_12
            drive.allow_ccw        <= fwd_eff && (next_state == PMIC_RUN); // see RULE_18
            drive.allow_cw         <= rev_eff && (next_state == PMIC_RUN); // see RULE_18
            drive.cam_detect       <= cam_now;
        end
    end

    // ----------------------------------------------------------------
    // Fault and warning outputs
    // ----------------------------------------------------------------
    // Warning output is low while the stroke warning stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_output   <= 1'b0;
            warning_output <= 1'b1;
            warning_code   <= WARN_NONE;
        end else begin
            fault_output   <= !alarm_active; // see RULE_04
            warning_output <= !any_stroke_off; // see RULE_15
            warning_code   <= any_stroke_off ? WARN_STROKE : WARN_NONE; // see RULE_15
        end
    end

    // Each pin shows the function its byte selects
    generate
        for (gi = 0; gi < OUT_PINS; gi++) begin : g_outpin
            logic [OUT_CODE_W-1:0] code;
            assign code = outsel[gi*OUT_CODE_W +: OUT_CODE_W];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_pins[gi] <= 1'b0;
                end else begin
                    unique case (code)
                        FUNC_FAULT:       out_pins[gi] <= !alarm_active;
                        FUNC_WARNING:     out_pins[gi] <= !any_stroke_off; // see RULE_16
                        FUNC_TRAVEL_DONE: out_pins[gi] <= travel_done; // see RULE_06
                        default:          out_pins[gi] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic fstop_q;
    logic stroke_q;
    logic alarm_q;
    logic cam_q;

    // Edge history for event detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fstop_q  <= 1'b1;
            stroke_q <= 1'b0;
            alarm_q  <= 1'b0;
            cam_q    <= 1'b0;
        end else begin
            fstop_q  <= (state == PMIC_FSTOP);
            stroke_q <= any_stroke_off;
            alarm_q  <= alarm_active;
            cam_q    <= cam_now;
        end
    end

    always_comb begin
        irq_event             = '0;
        irq_event[IRQ_FSTOP]  = (state == PMIC_FSTOP) && !fstop_q;
        irq_event[IRQ_STROKE] = any_stroke_off && !stroke_q; // see RULE_15
        irq_event[IRQ_ALARM]  = alarm_active && !alarm_q;
        irq_event[IRQ_CAM]    = cam_now && !cam_q;
    end

    // Set beats a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_en && (paddr == PMIC_OFF_IRQ_ST)) begin
            irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status() & irq_mask);
        end
    end

    // Next status, so irq moves with status
    function automatic logic [IRQ_W-1:0] next_irq_status();
        logic [IRQ_W-1:0] v;

        v = irq_status | irq_event;
        if (wr_en && (paddr == PMIC_OFF_IRQ_ST)) begin
            v = (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // APB read path
    // ----------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic        next_err;

    always_comb begin
        status_word         = '0;
        status_word[0]      = drive.run_auto;
        status_word[1]      = drive.home_return_mode;
        status_word[4:2]    = drive.prog_number;

        status_word[5]      = (state == PMIC_FSTOP);
        status_word[6]      = cam_now;
        status_word[7]      = fwd_eff;
        status_word[8]      = rev_eff;

        status_word[9]      = fault_output;
        status_word[10]     = warning_output;
        status_word[11]     = drive.run_jog;

        status_word[ST_WARN_LSB +: 8] = warning_code;
    end

    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        unique case (paddr)
            PMIC_OFF_CTRL:    next_rdata[CTRL_W-1:0] = ctrl;
            PMIC_OFF_OUTSEL:  next_rdata = outsel;
            PMIC_OFF_STATUS:  next_rdata = status_word;
            PMIC_OFF_IRQ_ST:  next_rdata[IRQ_W-1:0] = irq_status;
            PMIC_OFF_IRQ_MSK: next_rdata[IRQ_W-1:0] = irq_mask;
            default:          next_err = 1'b1;
        endcase
    end

    // Answer is prepared in setup, so every access completes with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // pmic_top

//--- verif/pmic_sva.sv
// Port checks bound onto pmic_top.
// Assumes one pclk domain; pins settle in eight edges.
`timescale 1ns/1ps

module pmic_sva (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Inputs watched
    input wire pmic_pkg::pmic_pins_t  pins,
    input wire logic                  alarm_active,
    // Outputs checked
    input wire pmic_pkg::pmic_drive_t drive,
    input wire logic                  fault_output,
    input wire logic                  warning_output,
    input wire logic [7:0]            warning_code,
    input wire logic                  irq
);
    import pmic_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Program lines as one word
    logic [2:0] prog_pins;
    assign prog_pins = {pins.prog_select_bit3, pins.prog_select_bit2, pins.prog_select_bit1};

    a_fault_follow: assert property (
        $past(presetn) |-> fault_output == !$past(alarm_active))
        else $error("fault mismatch");
    a_fstop_enter: assert property (
        !pins.forced_stop_input [*8] |-> drive.dyn_brake && !drive.power_stage_on)
        else $error("no stop entry");
    a_fstop_exit: assert property (
        pins.forced_stop_input [*8] |-> !drive.dyn_brake)
        else $error("no stop exit");
    a_brake_safe: assert property (
        drive.dyn_brake |-> !drive.power_stage_on && !drive.allow_ccw && !drive.allow_cw)
        else $error("motion under brake");
    a_mode_one: assert property (
        $onehot0({drive.run_auto, drive.run_jog, drive.home_return_mode}))
        else $error("two modes");
    a_prog_follow: assert property (
        $stable(prog_pins) [*8] |-> drive.prog_number == prog_pins)
        else $error("program mismatch");
    a_warn_code: assert property (
        warning_code == (warning_output ? WARN_NONE : WARN_STROKE))
        else $error("warning mismatch");
    a_stop_single: assert property (
        !(drive.sudden_stop && drive.slow_stop))
        else $error("two stop methods");
    a_stop_warn: assert property (
        (drive.sudden_stop || drive.slow_stop) |-> !warning_output && drive.servo_lock)
        else $error("stop without lock");
    a_dir_block: assert property (
        !warning_output |-> !(drive.allow_ccw && drive.allow_cw))
        else $error("both directions open");

    // Covers
    c_brake_off: cover property ($fell(drive.dyn_brake));
    c_warn_on: cover property ($fell(warning_output));
    c_home: cover property (drive.home_return_mode);
    c_irq: cover property ($rose(irq));
endmodule // pmic_sva

bind pmic_top pmic_sva chk_u (.pclk, .presetn, .pins, .alarm_active, .drive, .fault_output,
    .warning_output, .warning_code, .irq);

//--- verif/pmic_host_model.sv
// Host model driving the pin inputs.
// Assumes wanted levels from the bench.
`timescale 1ns/1ps

module pmic_host_model (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Levels the bench wants
    input  wire pmic_pkg::pmic_pins_t want,
    // Pins toward the block
    output pmic_pkg::pmic_pins_t      pins
);
    import pmic_pkg::*;
    // ------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------
    // Others move only with forced stop on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins <= '0;
        end else begin
            pins.forced_stop_input <= want.forced_stop_input;
            if (pins.forced_stop_input) begin
                pins <= want;
            end
        end
    end
endmodule // pmic_host_model

//--- verif/tb_top.sv
// Self-checking bench for pmic_top.
// Assumes nothing of APB wait states.
`timescale 1ns/1ps

module tb_top;
    import pmic_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic        pready, pslverr, erv, alarm_active = 1'b0, travel_done = 1'b0;
    logic        fault_output, warning_output, irq;
    logic [7:0]  warning_code;
    logic [3:0]  out_pins;
    logic [1:0]  dir;
    pmic_pins_t  want = '0, pins, p = '0;
    pmic_drive_t drive;
    int          fails = 0, checked = 0;
    logic [31:0] ctab [5] = '{32'h300, 32'h3a0, 32'h360, 32'h180, 32'h000};

    // 200 MHz clock
    initial forever #2.5 pclk = ~pclk;

    pmic_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pins, .alarm_active, .travel_done, .drive, .fault_output,
        .warning_output, .warning_code, .out_pins, .irq);
    pmic_host_model host_u (.pclk, .presetn, .want, .pins);

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    // Pins move at an edge; checks mid-cycle
    task automatic go(input int c);
        @(posedge pclk);
        want <= p;
        repeat (c) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Stroke ends {fwd, rev}
    function automatic logic [1:0] exp_dir(input logic [31:0] c, input pmic_pins_t q);
        return {!c[8] | c[5] | q.fwd_stroke_end_input, !c[9] | c[6] | q.rev_stroke_end_input};
    endfunction
    function automatic logic exp_cam(input logic pol, input logic pin);
        return pin == pol;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hc09d));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        go(10);
        rd(PMIC_OFF_CTRL, {22'h0, CTRL_RST});
        rd(PMIC_OFF_OUTSEL, OUTSEL_RST);
        rd(PMIC_OFF_IRQ_MSK, 32'h0);
        rd(12'hffc, 32'h0);
        chk(erv, 1'b1);
        chk({drive.dyn_brake, drive.power_stage_on}, 2'b10);
        apb(1'b1, PMIC_OFF_IRQ_MSK, 32'hf);
        // Forced stop
        {p.forced_stop_input, p.fwd_stroke_end_input, p.rev_stroke_end_input} = 3'b111;
        p.prox_cam_input = 1'b1;
        go(10);
        chk({drive.dyn_brake, drive.power_stage_on}, 2'b01);
        apb(1'b1, PMIC_OFF_IRQ_ST, 32'hf);
        go(0);
        chk(irq, 1'b0);
        p.forced_stop_input = 1'b0;
        go(10);
        chk({drive.dyn_brake, drive.allow_ccw, drive.allow_cw}, 3'b100);
        chk(irq, 1'b1);
        rd(PMIC_OFF_IRQ_ST, 32'h1);
        apb(1'b1, PMIC_OFF_IRQ_ST, 32'h1);
        p.forced_stop_input = 1'b1;
        go(10);
        chk(drive.dyn_brake, 1'b0);
        // Mode and program
        for (int i = 0; i < 10; i++) begin
            {p.auto_manual_select, p.prog_select_bit3, p.prog_select_bit2,
                p.prog_select_bit1} = (i < 2) ? {4{i[0]}} : 4'($urandom);
            go(8);
            chk(drive.prog_number, {p.prog_select_bit3, p.prog_select_bit2,
                p.prog_select_bit1});
            chk({drive.run_auto, drive.run_jog}, {p.auto_manual_select,
                !p.auto_manual_select});
        end
        apb(1'b1, PMIC_OFF_CTRL, 32'h307);
        p.auto_manual_select = 1'b1;
        go(8);
        chk({drive.home_return_mode, drive.run_auto}, 2'b10);
        apb(1'b1, PMIC_OFF_CTRL, 32'h300);
        // Alarm, outputs
        apb(1'b1, PMIC_OFF_IRQ_ST, 32'hf);
        alarm_active <= 1'b1;
        travel_done  <= 1'b1;
        go(2);
        chk({fault_output, out_pins}, 5'b00110);
        rd(PMIC_OFF_IRQ_ST, 32'h4);
        alarm_active <= 1'b0;
        apb(1'b1, PMIC_OFF_OUTSEL, 32'h1807_0000);
        go(2);
        chk({fault_output, out_pins}, 5'b11100);
        apb(1'b1, PMIC_OFF_OUTSEL, 32'h1707_0000);
        go(2);
        chk(out_pins, 4'b0100);
        apb(1'b1, PMIC_OFF_OUTSEL, OUTSEL_RST);
        // Stroke ends
        apb(1'b1, PMIC_OFF_IRQ_ST, 32'hf);
        {p.fwd_stroke_end_input, p.rev_stroke_end_input} = 2'b00;
        go(10);
        rd(PMIC_OFF_IRQ_ST, 32'h2);
        apb(1'b1, PMIC_OFF_IRQ_MSK, 32'h0);
        go(1);
        chk(irq, 1'b0);
        apb(1'b1, PMIC_OFF_IRQ_MSK, 32'hf);
        go(1);
        chk(irq, 1'b1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, PMIC_OFF_CTRL, ctab[i]);
            go(4);
            dir = exp_dir(ctab[i], p);
            chk({drive.allow_ccw, drive.allow_cw}, dir);
            chk({warning_output, out_pins[2]}, {2{&dir}});
            chk(warning_code, (&dir) ? WARN_NONE : WARN_STROKE);
            chk({drive.sudden_stop, drive.slow_stop}, (&dir) ? 2'b00 :
                {!ctab[i][7], ctab[i][7]});
        end
        // Cam
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, PMIC_OFF_CTRL, 32'h360 | (32'(i[1]) << CTRL_CAM_POL));
            p.prox_cam_input = i[0];
            go(8);
            chk(drive.cam_detect, exp_cam(i[1], i[0]));
        end
        report_and_stop();
    end
endmodule // tb_top
